/* File: src/msd_pkg.sv */
// Shared constants for the memory space decode and bus steer block
package msd_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	// On-chip data SRAM window
	localparam logic [15:0] SRAM_BASE       = 16'h0000;
	localparam logic [15:0] SRAM_LAST       = 16'h03ff;
	localparam int          SRAM_DEPTH      = 1024;
	// Internal ROM window, 32 Kbytes
	localparam logic [15:0] ROM_LAST        = 16'h7fff;
	// Stretch limits in machine cycles
	localparam int          STRETCH_MIN     = 2;
	localparam int          STRETCH_MAX     = 9;
	localparam int          CLK_PER_MC      = 4;
	localparam logic [7:0]  OP_PTR_DEC      = 8'ha5;
	// Register offsets on the control port
	localparam logic [3:0]  REG_PWR_CTRL    = 4'h0;
	localparam logic [3:0]  REG_PTR0_LO     = 4'h1;
	localparam logic [3:0]  REG_PTR0_HI     = 4'h2;
	localparam logic [3:0]  REG_PTR1_LO     = 4'h3;
	localparam logic [3:0]  REG_PTR1_HI     = 4'h4;
	localparam logic [3:0]  REG_DPSEL       = 4'h5;
	localparam logic [3:0]  REG_STRETCH     = 4'h6;
	localparam logic [3:0]  REG_STATUS      = 4'h7;
	// Field positions
	localparam int          PWR_SRAM_EN_BIT = 0;
	localparam int          PWR_WAIT_EN_BIT = 1;
	localparam logic [7:0]  PWR_RESET       = 8'h00;
	localparam logic [3:0]  STRETCH_RESET   = 4'h2;
endpackage : msd_pkg

/* File: src/msd_mc_tick.sv */
// Machine cycle enable divider
`timescale 1ns/1ps
module msd_mc_tick #(
	parameter int DIV = msd_pkg::CLK_PER_MC
) (
	input  wire logic i_clk,   // Core clock
	input  wire logic i_rst_b, // Sync reset, low
	input  wire logic i_clr,   // Restart phase
	output logic      o_tick   // One pulse per machine cycle
);
	// Divider counter is four bits wide
	if (DIV < 2 || DIV > 16) begin : g_div_chk
		$error("DIV must lie between 2 and 16");
	end

	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;

	// Next phase count
	always_comb begin
		cnt_nxt = cnt_r + 4'h1;
		if (i_clr || cnt_r == 4'(DIV - 1)) cnt_nxt = 4'h0;
	end

	// Register phase
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) cnt_r <= 4'h0;
		else          cnt_r <= cnt_nxt;
	end

	assign o_tick = (cnt_r == 4'(DIV - 1)) && !i_clr;

	chk_tick_period: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_tick |=> !o_tick [*3]) else $error("machine cycle shorter than four clocks");
endmodule : msd_mc_tick

/* File: src/msd_sram.sv */
// On-chip data SRAM with registered read data
`timescale 1ns/1ps
module msd_sram #(
	parameter int DEPTH = msd_pkg::SRAM_DEPTH,
	parameter int AW    = 10
) (
	input  wire logic          i_clk,   // Core clock
	input  wire logic          i_we,    // Write enable
	input  wire logic          i_re,    // Read enable
	input  wire logic [AW-1:0] i_addr,  // Word address
	input  wire logic [7:0]    i_wdata, // Write data
	output logic      [7:0]    o_rdata  // Registered read data
);
	// Address width must cover the depth exactly
	if (DEPTH != (1 << AW)) begin : g_depth_chk
		$error("DEPTH must equal 2**AW");
	end

	logic [7:0] mem [DEPTH];

	// Storage and read register
	always_ff @(posedge i_clk) begin
		if (i_we) mem[i_addr] <= i_wdata;
		if (i_re) o_rdata <= mem[i_addr];
	end
endmodule : msd_sram

/* File: src/msd_steer.sv */
// Memory space decode and external bus steer
// How it works
// - 1KB data SRAM at 0000H-03FFH, data moves
// - SRAM answers only while enable bit set
// - Reset clears enable; all moves go external
// - Fetches never read the data SRAM
// - Scratchpad is separate storage, not here
// - Program below 32K internal, above external
// - Code reads decode like instruction fetches
// - Data move lasts two to nine cycles
// - Machine cycle is four core clocks
// - Port 0 bus when external, else open-drain
// - Port 2 drives high address on bus
// - Wait pin is input when enabled
// - Second 16-bit pointer in two registers
// - Opcode A5H decrements active pointer
// - Enabled SRAM: above 03FFH still external
`timescale 1ns/1ps
module msd_steer (
	input  wire logic        i_clk,       // 40 MHz core clock
	input  wire logic        i_rst_b,     // Sync reset, low
	// Register port
	input  wire logic [3:0]  i_reg_addr,  // Register offset
	input  wire logic [7:0]  i_reg_wdata, // Write data
	input  wire logic        i_reg_wr,    // Write strobe
	input  wire logic        i_reg_rd,    // Read strobe
	output logic      [7:0]  o_reg_rdata, // Read data, next cycle
	// Core request port
	input  wire logic        i_req,       // Start access, one pulse
	input  wire logic [1:0]  i_kind,      // 0 fetch, 1 code read, 2 data move
	input  wire logic        i_wr,        // Data move is a write
	input  wire logic        i_use_ptr,   // Data move addressed by pointer
	input  wire logic [15:0] i_addr,      // Address when not by pointer
	input  wire logic [7:0]  i_wdata,     // Write data
	input  wire logic        i_op_valid,  // Opcode decoded this cycle
	input  wire logic [7:0]  i_opcode,    // Opcode value
	output logic             o_busy,      // Access in progress
	output logic             o_done,      // Access finished, one pulse
	output logic             o_int_rom,   // Served by internal ROM
	output logic [15:0]      o_rom_addr,  // Address to internal ROM
	input  wire logic [7:0]  i_rom_data,  // Internal ROM data
	output logic      [7:0]  o_rdata,     // Read result
	// Pins
	input  wire logic [7:0]  i_p0,        // Port 0 pin level
	output logic      [7:0]  o_p0,        // Port 0 out value
	output logic      [7:0]  o_p0_oe,     // Port 0 drive enable
	output logic      [7:0]  o_p2,        // Port 2 out value
	output logic             o_p2_bus,    // Port 2 strong drive
	output logic             o_ale,       // Address latch enable
	output logic             o_psen_b,    // Program store enable, low
	output logic             o_rd_b,      // Data read strobe, low
	output logic             o_wr_b,      // Data write strobe, low
	input  wire logic        i_wait_b     // Wait pin, low stalls
);
	typedef enum logic [2:0] {MSD_IDLE, MSD_ADDR, MSD_DATA, MSD_SRAM, MSD_DONE} msd_state_t;

	// Program registers
	logic [7:0]  pwr_r, pwr_nxt;
	logic [15:0] dp0_r, dp0_nxt, dp1_r, dp1_nxt;
	logic        dpsel_r, dpsel_nxt;
	logic [3:0]  stretch_r, stretch_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	// Access state
	msd_state_t  st_r, st_nxt;
	logic [15:0] a_r, a_nxt;
	logic [7:0]  wd_r, wd_nxt, res_r, res_nxt;
	logic [1:0]  kind_r, kind_nxt;
	logic        wr_r, wr_nxt;
	logic [3:0]  mc_r, mc_nxt;
	logic        tick;
	logic [15:0] req_addr;
	logic        sram_hit, rom_hit, sram_we, sram_re;
	logic [7:0]  sram_q;

	// True when a data move lands in the on-chip SRAM
	function automatic logic hits_sram(input logic [15:0] a, input logic en);
		return en && a <= msd_pkg::SRAM_LAST;
	endfunction : hits_sram

	msd_mc_tick u_tick (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_clr   (i_req && st_r == MSD_IDLE),
		.o_tick  (tick)
	);

	msd_sram u_sram (
		.i_clk   (i_clk),
		.i_we    (sram_we),
		.i_re    (sram_re),
		.i_addr  (req_addr[9:0]),
		.i_wdata (i_wdata),
		.o_rdata (sram_q)
	);

	// Request decode
	always_comb begin
		req_addr = i_use_ptr ? (dpsel_r ? dp1_r : dp0_r) : i_addr;
		if (i_kind != 2'd2) req_addr = i_addr;
		sram_hit = i_kind == 2'd2 &&
			hits_sram(req_addr, pwr_r[msd_pkg::PWR_SRAM_EN_BIT]);
		rom_hit  = i_kind != 2'd2 && req_addr <= msd_pkg::ROM_LAST;
		sram_we  = i_req && st_r == MSD_IDLE && sram_hit && i_wr;
		sram_re  = i_req && st_r == MSD_IDLE && sram_hit && !i_wr;
	end

	// Register port next values
	always_comb begin
		pwr_nxt     = pwr_r;
		dp0_nxt     = dp0_r;
		dp1_nxt     = dp1_r;
		dpsel_nxt   = dpsel_r;
		stretch_nxt = stretch_r;
		rdata_nxt   = 8'h00;
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				msd_pkg::REG_PWR_CTRL: pwr_nxt = i_reg_wdata;
				msd_pkg::REG_PTR0_LO:  dp0_nxt[7:0] = i_reg_wdata;
				msd_pkg::REG_PTR0_HI:  dp0_nxt[15:8] = i_reg_wdata;
				msd_pkg::REG_PTR1_LO:  dp1_nxt[7:0] = i_reg_wdata;
				msd_pkg::REG_PTR1_HI:  dp1_nxt[15:8] = i_reg_wdata;
				msd_pkg::REG_DPSEL: dpsel_nxt = i_reg_wdata[0];
				msd_pkg::REG_STRETCH: begin
					// Clamp into the legal two to nine range
					if (i_reg_wdata[3:0] < 4'(msd_pkg::STRETCH_MIN))
						stretch_nxt = 4'(msd_pkg::STRETCH_MIN);
					else if (i_reg_wdata[3:0] > 4'(msd_pkg::STRETCH_MAX) || i_reg_wdata[7:4] != 4'h0)
						stretch_nxt = 4'(msd_pkg::STRETCH_MAX);
					else
						stretch_nxt = i_reg_wdata[3:0];
				end
				default: ;
			endcase
		end
		// Pointer decrement on opcode A5H
		if (i_op_valid && i_opcode == msd_pkg::OP_PTR_DEC) begin
			if (dpsel_r) dp1_nxt = dp1_r - 16'h0001;
			else         dp0_nxt = dp0_r - 16'h0001;
		end
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				msd_pkg::REG_PWR_CTRL: rdata_nxt = pwr_r;
				msd_pkg::REG_PTR0_LO:  rdata_nxt = dp0_r[7:0];
				msd_pkg::REG_PTR0_HI:  rdata_nxt = dp0_r[15:8];
				msd_pkg::REG_PTR1_LO:  rdata_nxt = dp1_r[7:0];
				msd_pkg::REG_PTR1_HI:  rdata_nxt = dp1_r[15:8];
				msd_pkg::REG_DPSEL:   rdata_nxt = {7'h00, dpsel_r};
				msd_pkg::REG_STRETCH: rdata_nxt = {4'h0, stretch_r};
				msd_pkg::REG_STATUS:  rdata_nxt = {5'h00, st_r};
				default:              rdata_nxt = 8'h00;
			endcase
		end
	end

	// Register port flops
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pwr_r     <= msd_pkg::PWR_RESET;
			dp0_r     <= 16'h0000;
			dp1_r     <= 16'h0000;
			dpsel_r   <= 1'b0;
			stretch_r <= msd_pkg::STRETCH_RESET;
			rdata_r   <= 8'h00;
		end else begin
			pwr_r     <= pwr_nxt;
			dp0_r     <= dp0_nxt;
			dp1_r     <= dp1_nxt;
			dpsel_r   <= dpsel_nxt;
			stretch_r <= stretch_nxt;
			rdata_r   <= rdata_nxt;
		end
	end
	assign o_reg_rdata = rdata_r;

	// Access sequencer next values
	always_comb begin
		st_nxt   = st_r;
		a_nxt    = a_r;
		wd_nxt   = wd_r;
		res_nxt  = res_r;
		kind_nxt = kind_r;
		wr_nxt   = wr_r;
		mc_nxt   = mc_r;
		unique case (st_r)
			MSD_IDLE: if (i_req) begin
				a_nxt    = req_addr;
				wd_nxt   = i_wdata;
				kind_nxt = i_kind;
				wr_nxt   = i_wr && i_kind == 2'd2;
				mc_nxt   = 4'h0;
				if (sram_hit)     st_nxt = MSD_SRAM;
				else if (rom_hit) st_nxt = MSD_DONE;
				else              st_nxt = MSD_ADDR;
				if (rom_hit) res_nxt = i_rom_data;
			end
			MSD_ADDR: if (tick) begin
				st_nxt = MSD_DATA;
				mc_nxt = 4'h1;
			end
			MSD_DATA: if (tick) begin
				// Wait pin holds a data move open while enabled; fetches and code reads ignore it
				if (kind_r != 2'd2) begin
					st_nxt  = MSD_DONE;
					res_nxt = i_p0;
				end else if (mc_r + 4'h1 >= stretch_r &&
					!(pwr_r[msd_pkg::PWR_WAIT_EN_BIT] && !i_wait_b)) begin
					st_nxt  = MSD_DONE;
					res_nxt = i_p0;
				end else if (mc_r < 4'hf) begin
					mc_nxt = mc_r + 4'h1;
				end
			end
			MSD_SRAM: begin
				st_nxt  = MSD_DONE;
				res_nxt = wr_r ? res_r : sram_q;
			end
			MSD_DONE: st_nxt = MSD_IDLE;
			default:  st_nxt = MSD_IDLE;
		endcase
	end

	// Access sequencer flops
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st_r   <= MSD_IDLE;
			a_r    <= 16'h0000;
			wd_r   <= 8'h00;
			res_r  <= 8'h00;
			kind_r <= 2'd0;
			wr_r   <= 1'b0;
			mc_r   <= 4'h0;
		end else begin
			st_r   <= st_nxt;
			a_r    <= a_nxt;
			wd_r   <= wd_nxt;
			res_r  <= res_nxt;
			kind_r <= kind_nxt;
			wr_r   <= wr_nxt;
			mc_r   <= mc_nxt;
		end
	end

	// Core answer and ROM path
	assign o_busy     = st_r != MSD_IDLE;
	assign o_done     = st_r == MSD_DONE;
	assign o_rdata    = res_r;
	assign o_int_rom  = i_req && st_r == MSD_IDLE && rom_hit;
	assign o_rom_addr = req_addr;

	// Pin drive: bus only during external phases
	always_comb begin
		o_p0     = 8'hff;
		o_p0_oe  = 8'h00; // Open-drain idle: released
		o_p2     = 8'hff;
		o_p2_bus = 1'b0;
		o_ale    = 1'b0;
		o_psen_b = 1'b1;
		o_rd_b   = 1'b1;
		o_wr_b   = 1'b1;
		if (st_r == MSD_ADDR) begin
			o_p0     = a_r[7:0];
			o_p0_oe  = 8'hff;
			o_p2     = a_r[15:8];
			o_p2_bus = 1'b1;
			o_ale    = 1'b1;
		end else if (st_r == MSD_DATA) begin
			o_p2     = a_r[15:8];
			o_p2_bus = 1'b1;
			o_psen_b = kind_r == 2'd2;
			o_rd_b   = !(kind_r == 2'd2 && !wr_r);
			o_wr_b   = !(kind_r == 2'd2 && wr_r);
			o_p0     = wd_r;
			o_p0_oe  = (kind_r == 2'd2 && wr_r) ? 8'hff : 8'h00;
		end
	end

	chk_sram_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r == MSD_SRAM |-> o_rd_b && o_wr_b && o_p0_oe == 8'h00)
		else $error("strobe active on SRAM access");
	chk_reset_off: assert property (@(posedge i_clk)
		!i_rst_b |=> !pwr_r[msd_pkg::PWR_SRAM_EN_BIT]) else $error("SRAM enable not cleared");
	chk_fetch_nosram: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_req && !o_busy && i_kind != 2'd2 |=> st_r != MSD_SRAM)
		else $error("fetch served from SRAM");
	chk_high_ext: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_req && !o_busy && i_kind == 2'd2 && req_addr > msd_pkg::SRAM_LAST |=> st_r == MSD_ADDR)
		else $error("high data move not external");
	chk_rom_split: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_req && !o_busy && i_kind != 2'd2 |-> o_int_rom == (i_addr <= msd_pkg::ROM_LAST))
		else $error("ROM decode wrong");
	chk_move_min: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$rose(o_wr_b == 1'b0) |-> !o_wr_b [*4]) else $error("data move under two cycles");
	chk_bus_p2: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_ale |-> o_p2_bus && o_p0_oe == 8'hff && o_p2 == a_r[15:8] && o_p0 == a_r[7:0])
		else $error("address not on bus");
	chk_dec_ptr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_op_valid && i_opcode == msd_pkg::OP_PTR_DEC && !dpsel_r && !i_reg_wr
		|=> dp0_r == $past(dp0_r) - 16'h0001) else $error("pointer decrement wrong");
	chk_sram_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_req && !o_busy && i_kind == 2'd2 && !pwr_r[msd_pkg::PWR_SRAM_EN_BIT]
		|=> st_r == MSD_ADDR) else $error("SRAM used while disabled");
endmodule : msd_steer

/* File: tb/msd_ext_mem.sv */
// Behavioural external memory on the multiplexed address/data bus
`timescale 1ns/1ps
module msd_ext_mem (
	input  wire logic       i_clk,    // Core clock
	input  wire logic       i_slow,   // Stall each read or write strobe via wait
	input  wire logic       i_ale,    // Address latch enable
	input  wire logic [7:0] i_p0,     // Port 0 pin level
	input  wire logic [7:0] i_p2,     // Port 2 level
	input  wire logic       i_psen_b, // Program strobe, low
	input  wire logic       i_rd_b,   // Read strobe, low
	input  wire logic       i_wr_b,   // Write strobe, low
	output logic      [7:0] o_p0,     // Read data or changing junk
	output logic            o_wait_b  // Wait request, low stalls
);
	logic [7:0]  mem [0:65535];
	logic [15:0] addr_r = 16'h0000;
	logic [7:0]  junk_r = 8'h00;
	logic        strb_d = 1'b0;
	int          hold_r = 0;
	// Pattern the bench can predict
	initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
	// Latch address, store write data, time wait requests
	always @(posedge i_clk) begin
		if (i_ale)
			addr_r <= {i_p2, i_p0};
		if (!i_wr_b)
			mem[addr_r] <= i_p0;
		junk_r <= ~junk_r;
		strb_d <= !(i_rd_b && i_wr_b);
		if (i_slow && !strb_d && !(i_rd_b && i_wr_b))
			hold_r <= 6;
		else if (hold_r > 0)
			hold_r <= hold_r - 1;
	end
	// Drive only while a read strobe is low; junk otherwise
	assign o_p0     = (!i_rd_b || !i_psen_b) ? mem[addr_r] : junk_r;
	assign o_wait_b = (hold_r == 0);
endmodule : msd_ext_mem

/* File: tb/memory_space_decode_and_bus_steer_test.sv */
// Self-checking bench for the memory space decode and bus steer block
`timescale 1ns/1ps
module memory_space_decode_and_bus_steer_test;
	logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0;
	logic        wr = 1'b0, use_ptr = 1'b0, op_valid = 1'b0, slow = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, wdata = 8'h00, opcode = 8'h00;
	logic [1:0]  kind = 2'h0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  reg_rdata, rdata, p0_out, p0_oe, p2, mdl_p0, p0_pin, rom_data, got;
	logic [15:0] rom_addr;
	logic        busy, done, int_rom, p2_bus, ale, psen_b, rd_b, wr_b, wait_b, rom;
	int          fail_count = 0, n_tests = 0, cyc, nstb, cycles = 0;
	logic [7:0]  st [4] = '{8'h01, 8'h05, 8'h09, 8'h0f};
	logic [7:0]  eff [4] = '{8'h02, 8'h05, 8'h09, 8'h09};
	logic [15:0] len [4] = '{16'd9, 16'd21, 16'd37, 16'd37};

	always #12.5 clk = ~clk;
	// Pin level of port 0 and the internal ROM contents
	assign p0_pin   = (p0_out & p0_oe) | (mdl_p0 & ~p0_oe);
	assign rom_data = ~rom_addr[7:0] ^ rom_addr[15:8];

	msd_steer dut_u (
		.i_clk(clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_req(req),
		.i_kind(kind), .i_wr(wr), .i_use_ptr(use_ptr), .i_addr(addr), .i_wdata(wdata),
		.i_op_valid(op_valid), .i_opcode(opcode), .o_busy(busy), .o_done(done),
		.o_int_rom(int_rom), .o_rom_addr(rom_addr), .i_rom_data(rom_data), .o_rdata(rdata),
		.i_p0(p0_pin), .o_p0(p0_out), .o_p0_oe(p0_oe), .o_p2(p2), .o_p2_bus(p2_bus),
		.o_ale(ale), .o_psen_b(psen_b), .o_rd_b(rd_b), .o_wr_b(wr_b), .i_wait_b(wait_b)
	);
	msd_ext_mem mdl_u (
		.i_clk(clk), .i_slow(slow), .i_ale(ale), .i_p0(p0_pin), .i_p2(p2),
		.i_psen_b(psen_b), .i_rd_b(rd_b), .i_wr_b(wr_b), .o_p0(mdl_p0), .o_wait_b(wait_b)
	);

	function automatic logic [7:0] ext_pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction : ext_pat
	task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input logic [7:0] exp, input string nm);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(nm, {8'h00, exp}, {8'h00, reg_rdata});
	endtask : reg_read
	task automatic op(input logic [7:0] c);
		@(posedge clk);
		op_valid <= 1'b1;
		opcode   <= c;
		@(posedge clk);
		op_valid <= 1'b0;
	endtask : op
	// One access: cycles to done, data strobe cycles, result
	task automatic access(input logic [1:0] k, input logic w, input logic p,
		input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		req     <= 1'b1;
		kind    <= k;
		wr      <= w;
		use_ptr <= p;
		addr    <= a;
		wdata   <= d;
		@(negedge clk);
		rom  = int_rom;
		cyc  = 0;
		nstb = 0;
		@(posedge clk);
		req <= 1'b0;
		while (done !== 1'b1 && cyc < 300) begin
			@(negedge clk);
			cyc++;
			if (rd_b !== 1'b1 || wr_b !== 1'b1)
				nstb++;
		end
		check("done busy", 16'h0003, {14'h0000, busy, done});
		@(negedge clk);
		got = rdata;
		check("idle released", 16'h0000, {7'h00, busy, p0_oe});
	endtask : access
	// Program space read, internal below 8000h
	task automatic prog(input logic [1:0] k, input logic [15:0] a);
		access(k, 1'b0, 1'b0, a, 8'h00);
		check("rom select", {15'h0, ~a[15]}, {15'h0, rom});
		check("program data", {8'h00, a[15] ? ext_pat(a) : ~ext_pat(a)}, {8'h00, got});
		check("program cycles", a[15] ? 16'd9 : 16'd1, cyc[15:0]);
	endtask : prog
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// Ceiling on run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		reg_read(msd_pkg::REG_PWR_CTRL, 8'h00, "power reg");
		reg_read(msd_pkg::REG_STRETCH, 8'h02, "stretch");
		reg_read(msd_pkg::REG_STATUS, 8'h00, "status idle");
		reg_read(4'hc, 8'h00, "unmapped");
		$display("test reset finished");
		prog(2'd0, 16'h7fff);
		prog(2'd0, 16'h8000);
		prog(2'd1, 16'h0000);
		prog(2'd1, 16'hffff);
		access(2'd2, 1'b1, 1'b0, 16'h0123, 8'h3c);
		check("ext write", 16'h003c, {8'h00, mdl_u.mem[16'h0123]});
		check("ext strobes", 16'd4, nstb[15:0]);
		$display("test program space finished");
		reg_write(msd_pkg::REG_PWR_CTRL, 8'h01);
		access(2'd2, 1'b1, 1'b0, 16'h03ff, 8'h5a);
		check("sram strobes", 16'h0000, nstb[15:0]);
		check("ext untouched", {8'h00, ext_pat(16'h03ff)}, {8'h00, mdl_u.mem[16'h03ff]});
		access(2'd2, 1'b0, 1'b0, 16'h03ff, 8'h00);
		check("sram read", 16'h005a, {8'h00, got});
		check("sram cycles", 16'd2, cyc[15:0]);
		check("sram read strobes", 16'h0000, nstb[15:0]);
		access(2'd2, 1'b1, 1'b0, 16'h0400, 8'h66);
		check("above window", 16'h0066, {8'h00, mdl_u.mem[16'h0400]});
		access(2'd2, 1'b0, 1'b0, 16'h0400, 8'h00);
		check("above read", 16'h0066, {8'h00, got});
		prog(2'd0, 16'h03ff);
		reg_write(msd_pkg::REG_PWR_CTRL, 8'h00);
		access(2'd2, 1'b0, 1'b0, 16'h03ff, 8'h00);
		check("disabled read", {8'h00, ext_pat(16'h03ff)}, {8'h00, got});
		$display("test data sram finished");
		for (int i = 0; i < 4; i++) begin
			reg_write(msd_pkg::REG_STRETCH, st[i]);
			reg_read(msd_pkg::REG_STRETCH, eff[i], "stretch clamp");
			access(2'd2, 1'b1, 1'b0, 16'h2000, 8'h11);
			check("stretch cycles", len[i], cyc[15:0]);
		end
		reg_write(msd_pkg::REG_STRETCH, 8'h02);
		slow <= 1'b1;
		access(2'd2, 1'b1, 1'b0, 16'h2001, 8'h22);
		check("wait ignored", 16'd9, cyc[15:0]);
		reg_write(msd_pkg::REG_PWR_CTRL, 8'h02);
		access(2'd2, 1'b1, 1'b0, 16'h2002, 8'h23);
		check("wait stalls", 16'h0001, {15'h0, cyc > 9});
		slow <= 1'b0;
		$display("test stretch and wait finished");
		reg_write(msd_pkg::REG_PWR_CTRL, 8'h00);
		reg_write(msd_pkg::REG_PTR1_LO, 8'h00);
		reg_write(msd_pkg::REG_PTR1_HI, 8'h05);
		reg_write(msd_pkg::REG_DPSEL, 8'h01);
		op(8'h00);
		op(msd_pkg::OP_PTR_DEC);
		reg_read(msd_pkg::REG_PTR1_LO, 8'hff, "ptr1 low");
		reg_read(msd_pkg::REG_PTR1_HI, 8'h04, "ptr1 high");
		access(2'd2, 1'b1, 1'b1, 16'h0000, 8'h77);
		check("ptr write", 16'h0077, {8'h00, mdl_u.mem[16'h04ff]});
		reg_write(msd_pkg::REG_DPSEL, 8'h00);
		op(msd_pkg::OP_PTR_DEC);
		reg_read(msd_pkg::REG_PTR0_HI, 8'hff, "ptr0 wrap");
		reg_read(msd_pkg::REG_PTR0_LO, 8'hff, "ptr0 low");
		reg_read(msd_pkg::REG_PTR1_LO, 8'hff, "ptr1 kept");
		access(2'd2, 1'b1, 1'b1, 16'h0000, 8'h78);
		check("ptr0 write", 16'h0078, {8'h00, mdl_u.mem[16'hffff]});
		$display("test pointers finished");
		complete_run();
	end
endmodule : memory_space_decode_and_bus_steer_test
